// ===== afs_cmd_decode.sv
/*
  Command word classifier for the fault status bank.
  Assumes the word is stable while cmd_valid is high.
*/
`timescale 1ns/1ps
module afs_cmd_decode (
  input wire logic [15:0] cmd_word,
  output afs_pkg::afs_cmd_e cmd_class,
  output logic [4:0] cmd_addr
);

  // ---------------------------------------------------------------
  // classification
  // ---------------------------------------------------------------
  always_comb begin
    cmd_addr = cmd_word[12:8];
    if (cmd_word == afs_pkg::CMD_NOOP) begin
      cmd_class = afs_pkg::AFS_CMD_NOOP;
    end else if (cmd_word == afs_pkg::CMD_LOCK || cmd_word == afs_pkg::CMD_UNLOCK) begin
      cmd_class = afs_pkg::AFS_CMD_LOCKCTL;
    end else if (cmd_word == afs_pkg::CMD_RESET || cmd_word == afs_pkg::CMD_STANDBY
                 || cmd_word == afs_pkg::CMD_WAKEUP) begin
      cmd_class = afs_pkg::AFS_CMD_CONTROL;
    end else if (cmd_word[15:13] == afs_pkg::CMD_RREG_OP) begin
      cmd_class = afs_pkg::AFS_CMD_READ;
    end else if (cmd_word[15:13] == afs_pkg::CMD_WREG_OP
                 || cmd_word[15:13] == afs_pkg::CMD_WREGS_OP) begin
      cmd_class = afs_pkg::AFS_CMD_WRITE;
    end else begin
      cmd_class = afs_pkg::AFS_CMD_INVALID;
    end
  end

endmodule

// ===== afs_fault_status.sv
/*
  Fault status bank: general fault register and positive-input
  threshold register, read-only, returned on register reads; the general
  one is also returned on the no-op command status.
  Holds the sticky fault flags, the threshold summary and the
  registered command status response; the fault engines
  (comparators, watchdog, crc and hamming checks) live outside.
  Assumes a serial front end delivers decoded 16-bit command words
  as one-cycle strobes, and that the fault engines supply set pulses,
  cause levels and threshold comparator levels on clk.
  Assumes the negative threshold register lives outside and reports
  its flags as levels and each of its reads as a one-cycle strobe.
  Assumes the front end shifts the response word out; this block
  only holds it until the next command strobe replaces it.
  Assumes the serial status register read is decoded here, while
  its startup bit is a level owned by the power-up checker.
*/
`timescale 1ns/1ps

module afs_fault_status #(
  parameter int CHANNELS = afs_pkg::CHANNELS_FULL
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_word,
  input wire logic cmd_crc_fail,
  input wire logic hamming_enable,
  input wire logic hamming_uncorrectable,
  input wire logic device_locked,
  input wire logic sync_slave_mode,
  input wire logic resync_event,
  input wire logic watchdog_expired,
  input wire logic conversion_ready_signal,
  input wire logic shift_out_busy,
  input wire logic cs_fault_event,
  input wire logic cs_fault_cause,
  input wire logic frame_fault_event,
  input wire logic frame_fault_cause,
  input wire logic startup_fault,
  input wire logic [3:0] pos_compare,
  input wire logic [3:0] neg_flags,
  input wire logic neg_read_strobe,
  output logic cmd_accept,
  output logic cmd_discard,
  output logic rsp_valid,
  output logic [15:0] rsp_word,
  output logic [7:0] general_fault_status,
  output logic [7:0] positive_input_threshold_status,
  output logic [2:0] serial_status
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic pos_read_seen;
    logic neg_read_seen;
    logic input_fault_summary_flag;
    logic [3:0] pos_flags;
    logic rsp_valid;
    logic [15:0] rsp_word;
  } afs_state_s;

  afs_state_s state;
  afs_state_s next_state;

  // decoded command
  afs_pkg::afs_cmd_e cmd_class;
  logic [4:0] cmd_addr;
  logic good_cmd;
  logic bad_cmd;
  logic locked_bad;
  logic noop_cmd;
  logic read_general;
  logic read_serial;
  logic read_pos;

  // sticky flag outputs and their set terms
  logic command_fault_flag;
  logic watchdog_timeout_flag;
  logic resync_fault_flag;
  logic data_overrun_flag;
  logic check_fault_flag;
  logic cs_flag;
  logic frame_flag;
  logic resync_set;
  logic overrun_set;
  logic overrun_cause;
  logic check_set;

  // register images and response
  logic [7:0] general_value;
  logic [7:0] pos_value;
  logic [2:0] serial_value;
  logic [3:0] chan_mask;
  logic [15:0] rsp_next;

  function automatic logic [3:0] channel_mask(input int n);
    channel_mask = (n >= afs_pkg::CHANNELS_FULL) ? 4'hf : 4'h3;
  endfunction

  function automatic logic addr_hit(input logic [4:0] a, input logic [4:0] reg_addr);
    addr_hit = (a == reg_addr);
  endfunction

  // accepted register read aimed at one address
  function automatic logic read_hit(input logic ok, input afs_pkg::afs_cmd_e cls,
                                    input logic [4:0] a, input logic [4:0] reg_addr);
    read_hit = ok && cls == afs_pkg::AFS_CMD_READ && addr_hit(a, reg_addr);
  endfunction

  afs_cmd_decode u_decode (
    .cmd_word(cmd_word),
    .cmd_class(cmd_class),
    .cmd_addr(cmd_addr)
  );

  // ---------------------------------------------------------------
  // command screening
  // ---------------------------------------------------------------
  always_comb begin
    chan_mask = channel_mask(CHANNELS);
    good_cmd = cmd_valid && !cmd_crc_fail;
    locked_bad = device_locked && (cmd_class == afs_pkg::AFS_CMD_CONTROL
                 || cmd_class == afs_pkg::AFS_CMD_WRITE);
    bad_cmd = good_cmd && (cmd_class == afs_pkg::AFS_CMD_INVALID || locked_bad);
    cmd_accept = good_cmd && !bad_cmd;
    cmd_discard = cmd_valid && !cmd_accept;
    noop_cmd = cmd_accept && cmd_class == afs_pkg::AFS_CMD_NOOP;
    // a no-op is a transfer of the general register as well
    read_general = noop_cmd
                   || read_hit(cmd_accept, cmd_class, cmd_addr, afs_pkg::GENERAL_FAULT_ADDR);
    read_pos = read_hit(cmd_accept, cmd_class, cmd_addr, afs_pkg::POS_THRESH_ADDR);
    read_serial = read_hit(cmd_accept, cmd_class, cmd_addr, afs_pkg::SERIAL_STATUS_ADDR);
  end

  // ---------------------------------------------------------------
  // flag set and hold terms
  // ---------------------------------------------------------------
  // qualifiers are applied here so a mode bit that drops mid-pulse
  // cannot leave a half-qualified set term on a flag
  always_comb begin
    resync_set = resync_event && sync_slave_mode;
    overrun_set = conversion_ready_signal && shift_out_busy;
    // new data landing in the clearing cycle keeps the overrun flag up
    overrun_cause = overrun_set;
    check_set = (hamming_enable && hamming_uncorrectable)
                || (cmd_valid && cmd_crc_fail);
  end

  // ---------------------------------------------------------------
  // sticky flags
  // ---------------------------------------------------------------
  // a refused command in the clearing cycle outranks the clear
  afs_sticky_flag u_cmd_fault (
    .clk(clk),
    .resetn(resetn),
    .set_pulse(bad_cmd),
    .cause_level(1'b0),
    .clear_pulse(read_general),
    .flag(command_fault_flag)
  );

  // expiry is a one-shot event, so no cause level holds it
  afs_sticky_flag u_watchdog (
    .clk(clk),
    .resetn(resetn),
    .set_pulse(watchdog_expired),
    .cause_level(1'b0),
    .clear_pulse(read_general),
    .flag(watchdog_timeout_flag)
  );

  // resync has no documented clear; it follows the general transfer too
  afs_sticky_flag u_resync (
    .clk(clk),
    .resetn(resetn),
    .set_pulse(resync_set),
    .cause_level(1'b0),
    .clear_pulse(read_general),
    .flag(resync_fault_flag)
  );

  afs_sticky_flag u_overrun (
    .clk(clk),
    .resetn(resetn),
    .set_pulse(overrun_set),
    .cause_level(overrun_cause),
    .clear_pulse(read_general),
    .flag(data_overrun_flag)
  );

  afs_sticky_flag u_check (
    .clk(clk),
    .resetn(resetn),
    .set_pulse(check_set),
    .cause_level(1'b0),
    .clear_pulse(read_serial),
    .flag(check_fault_flag)
  );

  // a select fault still present survives the serial transfer
  afs_sticky_flag u_cs (
    .clk(clk),
    .resetn(resetn),
    .set_pulse(cs_fault_event),
    .cause_level(cs_fault_cause),
    .clear_pulse(read_serial),
    .flag(cs_flag)
  );

  // a short frame still present survives the serial transfer
  afs_sticky_flag u_frame (
    .clk(clk),
    .resetn(resetn),
    .set_pulse(frame_fault_event),
    .cause_level(frame_fault_cause),
    .clear_pulse(read_serial),
    .flag(frame_flag)
  );

  // ---------------------------------------------------------------
  // register images
  // ---------------------------------------------------------------
  always_comb begin
    serial_value = {startup_fault, cs_flag, frame_flag};
    general_value = afs_pkg::GENERAL_FAULT_RESET;
    general_value[afs_pkg::RESERVED_BIT] = 1'b0;
    general_value[afs_pkg::CMD_FAULT_BIT] = command_fault_flag;
    general_value[afs_pkg::SERIAL_FAULT_BIT] = |serial_value;
    general_value[afs_pkg::INPUT_FAULT_BIT] = state.input_fault_summary_flag;
    general_value[afs_pkg::WATCHDOG_BIT] = watchdog_timeout_flag;
    general_value[afs_pkg::RESYNC_BIT] = resync_fault_flag;
    general_value[afs_pkg::OVERRUN_BIT] = data_overrun_flag;
    general_value[afs_pkg::CHECK_BIT] = check_fault_flag;
  end

  // ---------------------------------------------------------------
  // threshold image
  // ---------------------------------------------------------------
  // upper nibble stays at its reset value: no write path exists
  always_comb begin
    pos_value = afs_pkg::POS_THRESH_RESET;
    pos_value[afs_pkg::POS_CH_LSB +: afs_pkg::POS_CH_WIDTH] = state.pos_flags;
  end

  // ---------------------------------------------------------------
  // command status response
  // ---------------------------------------------------------------
  always_comb begin
    // writes echo the command; status registers have no write path
    rsp_next = cmd_word;
    if (!cmd_accept) begin
      rsp_next = 16'h0000;
    end else if (noop_cmd) begin
      rsp_next = {8'h22, general_value};
    end else if (cmd_class == afs_pkg::AFS_CMD_READ) begin
      if (addr_hit(cmd_addr, afs_pkg::GENERAL_FAULT_ADDR)) begin
        rsp_next = {afs_pkg::CMD_RREG_OP, cmd_addr, general_value};
      end else if (addr_hit(cmd_addr, afs_pkg::POS_THRESH_ADDR)) begin
        rsp_next = {afs_pkg::CMD_RREG_OP, cmd_addr, pos_value};
      end else if (addr_hit(cmd_addr, afs_pkg::SERIAL_STATUS_ADDR)) begin
        rsp_next = {afs_pkg::CMD_RREG_OP, cmd_addr, 5'h00, serial_value};
      end else begin
        rsp_next = {afs_pkg::CMD_RREG_OP, cmd_addr, 8'h00};
      end
    end
  end

  // ---------------------------------------------------------------
  // threshold summary and response
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.pos_flags = pos_compare & chan_mask;
    if (read_pos) begin
      next_state.pos_read_seen = 1'b1;
    end
    if (neg_read_strobe) begin
      next_state.neg_read_seen = 1'b1;
    end
    // summary drops once both threshold registers were read and none is set
    if (next_state.pos_read_seen && next_state.neg_read_seen) begin
      next_state.input_fault_summary_flag = 1'b0;
      next_state.pos_read_seen = 1'b0;
      next_state.neg_read_seen = 1'b0;
    end
    if (|next_state.pos_flags || |(neg_flags & chan_mask)) begin
      next_state.input_fault_summary_flag = 1'b1;
    end
    next_state.rsp_valid = cmd_valid;
    // the word stands until the next command strobe replaces it
    if (cmd_valid) begin
      next_state.rsp_word = rsp_next;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rsp_valid = state.rsp_valid;
  assign rsp_word = state.rsp_word;
  assign general_fault_status = general_value;
  assign positive_input_threshold_status = pos_value;
  assign serial_status = serial_value;

endmodule

// ===== afs_fault_status_asserts.sv
/*
  Checker for the fault status bank, bound to its top module.
  Assumes inputs stay quiet while resetn is low.
*/
`timescale 1ns/1ps
module afs_fault_status_asserts #(
  parameter int CHANNELS = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_word,
  input wire logic cmd_crc_fail,
  input wire logic watchdog_expired,
  input wire logic conversion_ready_signal,
  input wire logic shift_out_busy,
  input wire logic [3:0] pos_compare,
  input wire logic cmd_accept,
  input wire logic cmd_discard,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_word,
  input wire logic [7:0] general_fault_status,
  input wire logic [7:0] positive_input_threshold_status,
  input wire logic [2:0] serial_status
);
  // --------------------------------------------------------------
  // sequences and properties
  // --------------------------------------------------------------
  localparam logic [3:0] MASK = (CHANNELS == 2) ? 4'h3 : 4'hf;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_noop;
    cmd_valid && !cmd_crc_fail && cmd_word == afs_pkg::CMD_NOOP;
  endsequence
  sequence s_gen_read;
    cmd_valid && cmd_accept && (cmd_word == afs_pkg::CMD_NOOP || cmd_word == 16'h2200);
  endsequence
  property p_rsp; 1'b1 |=> rsp_valid == $past(cmd_valid); endproperty
  property p_bit7; general_fault_status[7] == 1'b0; endproperty
  property p_top; positive_input_threshold_status[7:4] == 4'h0; endproperty
  property p_spi; general_fault_status[5] == |serial_status; endproperty
  property p_excl; cmd_valid |-> cmd_accept ^ cmd_discard; endproperty
  property p_noop; s_noop |=> rsp_word == {8'h22, $past(general_fault_status)}; endproperty
  property p_refuse;
    cmd_valid && cmd_discard && !cmd_crc_fail |=> rsp_word == 16'h0000 && general_fault_status[6];
  endproperty
  property p_crc; cmd_valid && cmd_crc_fail |-> cmd_discard ##1 general_fault_status[0]; endproperty
  property p_wdt; watchdog_expired |=> general_fault_status[3]; endproperty
  property p_wdt_clr; s_gen_read ##0 !watchdog_expired |=> !general_fault_status[3]; endproperty
  property p_ovr; conversion_ready_signal && shift_out_busy |=> general_fault_status[1]; endproperty
  property p_pos;
    $past(resetn) |-> positive_input_threshold_status[3:0] == ($past(pos_compare) & MASK);
  endproperty
  a_rsp: assert property (p_rsp) else $error("response strobe timing wrong");
  a_bit7: assert property (p_bit7) else $error("general bit 7 set");
  a_top: assert property (p_top) else $error("threshold top nibble set");
  a_spi: assert property (p_spi) else $error("serial summary bit wrong");
  a_excl: assert property (p_excl) else $error("accept and discard clash");
  a_noop: assert property (p_noop) else $error("no-op response wrong");
  a_refuse: assert property (p_refuse) else $error("refused command wrong");
  a_crc: assert property (p_crc) else $error("crc failure not handled");
  a_wdt: assert property (p_wdt) else $error("watchdog flag not set");
  a_wdt_clr: assert property (p_wdt_clr) else $error("watchdog flag not cleared");
  a_ovr: assert property (p_ovr) else $error("overrun flag not set");
  a_pos: assert property (p_pos) else $error("threshold flags wrong");
endmodule

bind afs_fault_status afs_fault_status_asserts #(.CHANNELS(CHANNELS)) afs_fault_status_asserts_i (
  .clk, .resetn, .cmd_valid, .cmd_word, .cmd_crc_fail, .watchdog_expired,
  .conversion_ready_signal, .shift_out_busy, .pos_compare, .cmd_accept, .cmd_discard,
  .rsp_valid, .rsp_word, .general_fault_status, .positive_input_threshold_status,
  .serial_status);

// ===== afs_fault_status_tb.sv
/*
  Self-checking bench for the fault status bank.
  Assumes the host model and the bound checker are compiled with it.
*/
`timescale 1ns/1ps
module afs_fault_status_tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [6:0] ev = 7'h00;
  logic [6:0] lv = 7'h00;
  logic [3:0] pos = 4'h0;
  logic [3:0] neg = 4'h0;
  logic cmd_valid, cmd_crc_fail, cmd_accept, cmd_discard, rsp_valid, sticky;
  logic [15:0] cmd_word, rsp_word;
  logic [7:0] gen, posr;
  logic [2:0] ser;
  logic [1:0] ad;
  int fail_count = 0;
  int checked = 0;
  int seed = 32'hd4b9;
  localparam logic [1:0] ACC = 2'b10;
  localparam logic [1:0] DIS = 2'b01;
  logic [15:0] ctl [6] = '{afs_pkg::CMD_RESET, afs_pkg::CMD_STANDBY, afs_pkg::CMD_WAKEUP,
    afs_pkg::CMD_LOCK, afs_pkg::CMD_UNLOCK, 16'h2300};
  always #50 clk = ~clk;
  afs_fault_status #(.CHANNELS(4)) afs_fault_status_i (
    .clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .cmd_crc_fail(cmd_crc_fail), .hamming_enable(lv[0]), .hamming_uncorrectable(ev[3]),
    .device_locked(lv[1]), .sync_slave_mode(lv[2]), .resync_event(ev[2]),
    .watchdog_expired(ev[0]), .conversion_ready_signal(ev[1]), .shift_out_busy(lv[3]),
    .cs_fault_event(ev[4]), .cs_fault_cause(lv[4]), .frame_fault_event(ev[5]),
    .frame_fault_cause(lv[5]), .startup_fault(lv[6]), .pos_compare(pos), .neg_flags(neg),
    .neg_read_strobe(ev[6]), .cmd_accept(cmd_accept), .cmd_discard(cmd_discard),
    .rsp_valid(rsp_valid), .rsp_word(rsp_word), .general_fault_status(gen),
    .positive_input_threshold_status(posr), .serial_status(ser));
  afs_host_model afs_host_model_i (.clk(clk), .cmd_accept(cmd_accept),
    .cmd_discard(cmd_discard), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .cmd_crc_fail(cmd_crc_fail));
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [15:0] rd(input logic [4:0] a, input logic [7:0] d);
    return {3'b001, a, d};
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cmd(input logic [15:0] w, input logic crc, input logic [1:0] ead,
                     input logic [15:0] ersp);
    afs_host_model_i.issue(w, crc, ad);
    chk("accept_discard", 16'(ad), 16'(ead));
    chk("rsp_valid", 16'(rsp_valid), 16'h0001);
    chk("rsp_word", rsp_word, ersp);
  endtask
  task automatic pulse(input logic [6:0] m);
    @(negedge clk);
    ev = m;
    @(negedge clk);
    ev = 7'h00;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    stop_test();
  end
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    chk("general", 16'(gen), 16'h0000);
    chk("pos_thresh", 16'(posr), 16'h0000);
    cmd(16'h2200, 1'b0, ACC, rd(5'h02, 8'h00));
    cmd(16'he000, 1'b0, DIS, 16'h0000);
    cmd(afs_pkg::CMD_NOOP, 1'b0, ACC, 16'h2240);
    chk("general", 16'(gen), 16'h0000);
    for (int i = 0; i < 12; i++) begin
      lv[1] = (i > 5);
      afs_host_model_i.issue(ctl[i % 6], 1'b0, ad);
      chk("lock_filter", 16'(ad), 16'((i > 5 && i < 9) ? DIS : ACC));
    end
    cmd(16'h4200, 1'b0, DIS, 16'h0000);
    cmd(afs_pkg::CMD_NOOP, 1'b0, ACC, 16'h2240);
    lv[1] = 1'b0;
    cmd(16'h4255, 1'b0, ACC, 16'h4255);
    cmd(16'h4355, 1'b0, ACC, 16'h4355);
    cmd(16'h2300, 1'b0, ACC, rd(5'h03, 8'h00));
    chk("general", 16'(gen), 16'h0000);
    pulse(7'h01);
    chk("general", 16'(gen), 16'h0008);
    cmd(afs_pkg::CMD_NOOP, 1'b0, ACC, 16'h2208);
    pulse(7'h04);
    lv[2] = 1'b1;
    chk("general", 16'(gen), 16'h0000);
    pulse(7'h04);
    chk("general", 16'(gen), 16'h0004);
    lv[3] = 1'b1;
    pulse(7'h02);
    chk("general", 16'(gen), 16'h0006);
    cmd(afs_pkg::CMD_NOOP, 1'b0, ACC, 16'h2206);
    lv[3:2] = 2'b00;
    pulse(7'h0a);
    lv[0] = 1'b1;
    chk("general", 16'(gen), 16'h0000);
    pulse(7'h08);
    cmd(afs_pkg::CMD_NOOP, 1'b1, DIS, 16'h0000);
    cmd(afs_pkg::CMD_NOOP, 1'b0, ACC, 16'h2201);
    cmd(16'h2500, 1'b0, ACC, rd(5'h05, 8'h00));
    chk("general", 16'(gen), 16'h0000);
    for (int k = 0; k < 4; k++) begin
      lv[4 + k % 2] = (k > 1);
      pulse(7'h10 << (k % 2));
      chk("serial", 16'(ser), 16'(3'b010 >> (k % 2)));
      cmd(afs_pkg::CMD_NOOP, 1'b0, ACC, 16'h2220);
      cmd(16'h2500, 1'b0, ACC, rd(5'h05, 8'(3'b010 >> (k % 2))));
      chk("general", 16'(gen), (k > 1) ? 16'h0020 : 16'h0000);
      lv[5:4] = 2'b00;
      cmd(16'h2500, 1'b0, ACC, rd(5'h05, 8'((k > 1) ? (3'b010 >> (k % 2)) : 3'b000)));
    end
    cmd(16'h2500, 1'b0, ACC, rd(5'h05, 8'h00));
    sticky = 1'b0;
    for (int i = 0; i < 10; i++) begin
      pos = (i == 0) ? 4'hf : (i == 9) ? 4'h0 : 4'($random(seed));
      sticky = sticky | (|pos);
      repeat (2) @(negedge clk);
      chk("pos_thresh", 16'(posr), 16'({4'h0, pos}));
      chk("input_fault", 16'(gen[4]), 16'(sticky));
    end
    cmd(16'h2300, 1'b0, ACC, rd(5'h03, 8'h00));
    @(negedge clk);
    chk("input_fault", 16'(gen[4]), 16'h0001);
    pulse(7'h40);
    @(negedge clk);
    chk("input_fault", 16'(gen[4]), 16'h0000);
    neg = 4'h2;
    repeat (2) @(negedge clk);
    neg = 4'h0;
    pulse(7'h40);
    chk("input_fault", 16'(gen[4]), 16'h0001);
    cmd(16'h2300, 1'b0, ACC, rd(5'h03, 8'h00));
    @(negedge clk);
    chk("input_fault", 16'(gen[4]), 16'h0000);
    // second reset with a flag pending
    pulse(7'h01);
    resetn = 1'b0;
    @(negedge clk);
    chk("general", 16'(gen), 16'h0000);
    resetn = 1'b1;
    cmd(afs_pkg::CMD_NOOP, 1'b0, ACC, 16'h2200);
    stop_test();
  end
endmodule

// ===== afs_host_model.sv
/*
  Host side model: issues one command word per call.
  Assumes the block answers accept/discard in the strobe cycle.
*/
`timescale 1ns/1ps
module afs_host_model (
  input wire logic clk,
  input wire logic cmd_accept,
  input wire logic cmd_discard,
  output logic cmd_valid,
  output logic [15:0] cmd_word,
  output logic cmd_crc_fail
);
  // --------------------------------------------------------------
  // command issue
  // --------------------------------------------------------------
  initial begin
    cmd_valid = 1'b0;
    cmd_word = 16'hffff;
    cmd_crc_fail = 1'b0;
  end
  task automatic issue(input logic [15:0] w, input logic crc, output logic [1:0] ad);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_word = w;
    cmd_crc_fail = crc;
    @(posedge clk);
    ad = {cmd_accept, cmd_discard};
    @(negedge clk);
    cmd_valid = 1'b0;
    // released word must not keep showing the last value
    cmd_word = ~w;
    cmd_crc_fail = 1'b0;
  endtask
endmodule

// ===== afs_pkg.sv
/*
  Package for the converter fault status bank: register addresses,
  field positions, reset values and the command codes it decodes.
  Assumes a command decoder upstream hands over 16-bit command words.
*/
package afs_pkg;

  // ---------------------------------------------------------------
  // register addresses and reset values
  // ---------------------------------------------------------------
  localparam logic [4:0] GENERAL_FAULT_ADDR = 5'h02;
  localparam logic [4:0] POS_THRESH_ADDR = 5'h03;
  localparam logic [4:0] NEG_THRESH_ADDR = 5'h04;
  localparam logic [4:0] SERIAL_STATUS_ADDR = 5'h05;
  localparam logic [7:0] GENERAL_FAULT_RESET = 8'h00;
  localparam logic [7:0] POS_THRESH_RESET = 8'h00;

  // ---------------------------------------------------------------
  // general fault register field positions
  // ---------------------------------------------------------------
  localparam int RESERVED_BIT = 7;
  localparam int CMD_FAULT_BIT = 6;
  localparam int SERIAL_FAULT_BIT = 5;
  localparam int INPUT_FAULT_BIT = 4;
  localparam int WATCHDOG_BIT = 3;
  localparam int RESYNC_BIT = 2;
  localparam int OVERRUN_BIT = 1;
  localparam int CHECK_BIT = 0;

  // positive threshold register: channel flags in low nibble
  localparam int POS_CH_LSB = 0;
  localparam int POS_CH_WIDTH = 4;
  localparam int CHANNELS_FULL = 4;
  localparam int CHANNELS_SMALL = 2;

  // ---------------------------------------------------------------
  // command words (upper 16 bits of the device word)
  // ---------------------------------------------------------------
  localparam logic [15:0] CMD_NOOP = 16'h0000;
  localparam logic [15:0] CMD_RESET = 16'h0011;
  localparam logic [15:0] CMD_STANDBY = 16'h0022;
  localparam logic [15:0] CMD_WAKEUP = 16'h0033;
  localparam logic [15:0] CMD_LOCK = 16'h0555;
  localparam logic [15:0] CMD_UNLOCK = 16'h0655;
  localparam logic [2:0] CMD_RREG_OP = 3'h1;
  localparam logic [2:0] CMD_REGISTER_READ_COMMAND_OP = 3'h1;
  localparam logic [2:0] CMD_WREG_OP = 3'h2;
  localparam logic [2:0] CMD_WREGS_OP = 3'h3;

  typedef enum logic [2:0] {
    AFS_CMD_INVALID,
    AFS_CMD_NOOP,
    AFS_CMD_CONTROL,
    AFS_CMD_LOCKCTL,
    AFS_CMD_READ,
    AFS_CMD_WRITE
  } afs_cmd_e;

endpackage

// ===== afs_sticky_flag.sv
/*
  One sticky fault flag: set by an event, cleared by a transfer,
  held while the cause persists.
  Assumes set and clear are one-cycle pulses on clk.
*/
`timescale 1ns/1ps
module afs_sticky_flag (
  input wire logic clk,
  input wire logic resetn,
  input wire logic set_pulse,
  input wire logic cause_level,
  input wire logic clear_pulse,
  output logic flag
);

  typedef struct packed {
    logic flag;
  } afs_flag_s;

  afs_flag_s state;
  afs_flag_s next_state;

  // ---------------------------------------------------------------
  // set beats clear; a persisting cause keeps the flag up
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (clear_pulse) begin
      next_state.flag = cause_level;
    end
    if (set_pulse) begin
      next_state.flag = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flag = state.flag;

endmodule
